// >>> design/dsbsp_device.sv
// Memory end of the double-data-rate separate-I/O two-word burst SRAM port.
// Assumes link strobes are synchronous to clk_in and toggled by the controller end.
//
// Summary of operation
// [R1] Recalibrate drive impedance every 1024 cycles.
// [R2] Two free-running echo clocks follow output pair.
// [R3] Single clock mode echoes the input strobes.
// [R4] PLL locks after 20 us stable clock.
// [R5] Clocks stopped 30 ns reset PLL; relock.
// [R6] Controller keeps input clock within PLL range.
// [R7] pll_off_n low gives legacy one-cycle latency.
// [R8] Write words taken at next strobe rises.
// [R9] Read words driven 1.5 cycles after command.
// [R10] Stopped clocks freeze inputs and outputs.
// [R11] Power up deselected, read data floating.
// [R12] Burst accesses address A then A+1.
// [R13] Lane masks low commit their byte.
// [R14] Both masks high store nothing.
// [R15] Masks may differ between burst halves.
// [R16] Write on input rises, read on output rises.
// [R17] Stop clocks with equal inputs, outputs high.
// [R18] Deselect finishes reads, then floats outputs.
// [R19] Single clock mode strapped by high outputs.
// [R20] Posted write commits at next write.
// [R21] No commands until PLL lock elapsed.
module dsbsp_device
  import dsbsp_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  dsbsp_link_if.dev link,
  input wire logic [ZQ_CODE_W-1:0] impedance_ref_pin_in,
  output logic [ZQ_CODE_W-1:0] drive_code_out,
  output logic cal_pulse_out,
  output logic pll_locked_out,
  output logic single_clock_out
);
  // Array word holds both burst halves: index 0 is A+0, index 1 is A+1.
  logic [1:0][WORD_W-1:0] mem_q [0:MEM_DEPTH-1];

  logic sa_q, sb_q, pa_q, pb_q;
  logic launch_a, launch_b, rise_a, rise_b, lrise_a, lrise_b, stopped, cmd_ok, take;
  logic strap_done_q, strap_done_d, single_q, single_d;
  logic [1:0] stop_cnt_q, stop_cnt_d;
  logic [9:0] lock_cnt_q, lock_cnt_d;
  logic locked_q, locked_d;
  logic [9:0] zq_cnt_q, zq_cnt_d;
  logic [ZQ_CODE_W-1:0] zq_code_q, zq_code_d;
  logic cal_q, cal_d;

  logic wcmd_v_q, wcmd_v_d, w0_v_q, w0_v_d, pend_v_q, pend_v_d, commit_en;
  logic [ADDR_W-1:0] wcmd_addr_q, wcmd_addr_d, w0_addr_q, w0_addr_d, pend_addr_q, pend_addr_d;
  logic [WORD_W-1:0] w0_data_q, w0_data_d;
  logic [1:0] w0_mask_q, w0_mask_d;
  logic [1:0][WORD_W-1:0] pend_data_q, pend_data_d, commit_word, rd_word, rd_raw;
  logic [1:0][1:0] pend_mask_q, pend_mask_d;
  logic bypass_hit;

  logic [1:0] slot_v_q, slot_v_d;
  logic [2:0] slot_cnt_q [2];
  logic [2:0] slot_cnt_d [2];
  logic [1:0][WORD_W-1:0] slot_data_q [2];
  logic [1:0][WORD_W-1:0] slot_data_d [2];
  logic ld_sel_q, ld_sel_d;
  logic [WORD_W-1:0] q_q, q_d;
  logic oe_q, oe_d, ret_a_q, ret_a_d, ret_b_q, ret_b_d;

  // Strobes are sampled levels, so a stopped clock simply yields no edges and nothing advances except the stop and calibration counters.
  assign rise_a = link.in_strobe_a & ~sa_q; // [R10] [R16]
  assign rise_b = link.in_strobe_b & ~sb_q; // [R16]
  assign launch_a = single_q ? link.in_strobe_a : link.out_phase_a; // [R3] [R16]
  assign launch_b = single_q ? link.in_strobe_b : link.out_phase_b; // [R3] [R16]
  assign lrise_a = launch_a & ~pa_q;
  assign lrise_b = launch_b & ~pb_q;
  assign stopped = (link.in_strobe_a == sa_q) && (link.in_strobe_b == sb_q);
  assign cmd_ok = strap_done_q & (~link.pll_off_n | locked_q); // [R7]
  assign take = rise_a & cmd_ok & ~link.cmd_valid_n; // [R8] [R9]

  always_comb begin
    strap_done_d = 1'b1;
    single_d = single_q;
    if (!strap_done_q) begin
      single_d = link.out_phase_a & link.out_phase_b; // [R19]
    end
    stop_cnt_d = stopped ? ((stop_cnt_q == 2'h3) ? stop_cnt_q : 2'(stop_cnt_q + 2'h1)) : 2'h0;
    lock_cnt_d = lock_cnt_q;
    locked_d = locked_q;
    if (stop_cnt_d >= 2'(PLL_STOP_CYC)) begin
      lock_cnt_d = 10'h000; // [R5]
      locked_d = 1'b0;
    end else if (!stopped && !locked_q) begin
      lock_cnt_d = 10'(lock_cnt_q + 10'h001);
      locked_d = (lock_cnt_q == 10'(PLL_LOCK_CYC - 1)); // [R4] [R5]
    end
    zq_cnt_d = 10'(zq_cnt_q + 10'h001);
    zq_code_d = zq_code_q;
    cal_d = 1'b0;
    if (zq_cnt_q == 10'(ZQ_PERIOD_CYC - 1)) begin
      zq_cnt_d = 10'h000;
      zq_code_d = impedance_ref_pin_in; // [R1]
      cal_d = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sa_q <= 1'b0;
      sb_q <= 1'b0;
      pa_q <= 1'b0;
      pb_q <= 1'b0;
      strap_done_q <= 1'b0;
      single_q <= 1'b0;
      stop_cnt_q <= 2'h0;
      lock_cnt_q <= 10'h000;
      locked_q <= 1'b0;
      zq_cnt_q <= 10'h000;
      zq_code_q <= ZQ_CODE_RST;
      cal_q <= 1'b0;
    end else begin
      sa_q <= link.in_strobe_a;
      sb_q <= link.in_strobe_b;
      pa_q <= launch_a;
      pb_q <= launch_b;
      strap_done_q <= strap_done_d;
      single_q <= single_d;
      stop_cnt_q <= stop_cnt_d;
      lock_cnt_q <= lock_cnt_d;
      locked_q <= locked_d;
      zq_cnt_q <= zq_cnt_d;
      zq_code_q <= zq_code_d;
      cal_q <= cal_d;
    end
  end

  // Commit merges the posted burst into the array; reads see the posted burst through a bypass.
  assign rd_raw = mem_q[link.addr];
  assign bypass_hit = pend_v_q && (pend_addr_q == link.addr);
  for (genvar w = 0; w < 2; w++) begin : g_word
    dsbsp_lane_merge u_commit (
      .old_in(mem_q[pend_addr_q][w]),
      .new_in(pend_data_q[w]),
      .mask_n_in(pend_mask_q[w]),
      .merged_out(commit_word[w])
    );
    dsbsp_lane_merge u_bypass (
      .old_in(rd_raw[w]),
      .new_in(pend_data_q[w]),
      .mask_n_in(bypass_hit ? pend_mask_q[w] : 2'h3),
      .merged_out(rd_word[w])
    );
  end

  always_comb begin
    wcmd_v_d = wcmd_v_q;
    wcmd_addr_d = wcmd_addr_q;
    w0_v_d = w0_v_q;
    w0_addr_d = w0_addr_q;
    w0_data_d = w0_data_q;
    w0_mask_d = w0_mask_q;
    pend_v_d = pend_v_q;
    pend_addr_d = pend_addr_q;
    pend_data_d = pend_data_q;
    pend_mask_d = pend_mask_q;
    commit_en = 1'b0;
    if (rise_b && w0_v_q) begin
      commit_en = pend_v_q; // [R20]
      pend_v_d = 1'b1;
      pend_addr_d = w0_addr_q;
      pend_data_d = {link.wdata, w0_data_q}; // [R8] [R12]
      pend_mask_d = {{link.lane1_write_mask_n, link.lane0_write_mask_n}, w0_mask_q}; // [R14] [R15]
      w0_v_d = 1'b0;
    end
    if (rise_a) begin
      w0_v_d = wcmd_v_q;
      if (wcmd_v_q) begin
        w0_addr_d = wcmd_addr_q;
        w0_data_d = link.wdata; // [R8]
        w0_mask_d = {link.lane1_write_mask_n, link.lane0_write_mask_n}; // [R13]
      end
      wcmd_v_d = take & ~link.read_not_write;
      wcmd_addr_d = link.addr;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wcmd_v_q <= 1'b0;
      wcmd_addr_q <= '0;
      w0_v_q <= 1'b0;
      w0_addr_q <= '0;
      w0_data_q <= '0;
      w0_mask_q <= 2'h3;
      pend_v_q <= 1'b0;
      pend_addr_q <= '0;
      pend_data_q <= '0;
      pend_mask_q <= 4'hF;
    end else begin
      wcmd_v_q <= wcmd_v_d;
      wcmd_addr_q <= wcmd_addr_d;
      w0_v_q <= w0_v_d;
      w0_addr_q <= w0_addr_d;
      w0_data_q <= w0_data_d;
      w0_mask_q <= w0_mask_d;
      pend_v_q <= pend_v_d;
      pend_addr_q <= pend_addr_d;
      pend_data_q <= pend_data_d;
      pend_mask_q <= pend_mask_d;
    end
  end

  // The array has no reset; its content is undefined until written.
  always_ff @(posedge clk_in) begin
    if (commit_en) begin
      mem_q[pend_addr_q] <= commit_word; // [R20]
    end
  end

  always_comb begin
    logic [2:0] first;
    logic [2:0] n;
    logic drove;
    first = link.pll_off_n ? RD_EDGE_DDR2 : RD_EDGE_LEGACY; // [R7] [R9]
    n = 3'h0;
    drove = 1'b0;
    q_d = q_q;
    oe_d = oe_q;
    slot_v_d = slot_v_q;
    slot_cnt_d = slot_cnt_q;
    slot_data_d = slot_data_q;
    ld_sel_d = ld_sel_q;
    for (int i = 0; i < 2; i++) begin
      if (slot_v_q[i] && (lrise_a || lrise_b)) begin
        n = 3'(slot_cnt_q[i] + 3'h1);
        slot_cnt_d[i] = n;
        if (n == first) begin
          q_d = slot_data_q[i][0]; // [R9] [R12]
          drove = 1'b1;
        end else if (n == 3'(first + 3'h1)) begin
          q_d = slot_data_q[i][1]; // [R9] [R12]
          drove = 1'b1;
          slot_v_d[i] = 1'b0;
        end
      end
    end
    if (drove) begin
      oe_d = 1'b1;
    end else if (lrise_a && (slot_v_q == 2'h0)) begin
      oe_d = 1'b0; // [R18]
    end
    if (take && link.read_not_write) begin
      slot_v_d[ld_sel_q] = 1'b1;
      slot_cnt_d[ld_sel_q] = 3'h0;
      slot_data_d[ld_sel_q] = rd_word; // [R20]
      ld_sel_d = ~ld_sel_q;
    end
    ret_a_d = launch_a; // [R2] [R3]
    ret_b_d = launch_b; // [R2] [R3]
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      slot_v_q <= 2'h0;
      slot_cnt_q <= '{default: 3'h0};
      slot_data_q <= '{default: '0};
      ld_sel_q <= 1'b0;
      q_q <= '0;
      oe_q <= 1'b0; // [R11]
      ret_a_q <= 1'b0;
      ret_b_q <= 1'b0;
    end else begin
      slot_v_q <= slot_v_d;
      slot_cnt_q <= slot_cnt_d;
      slot_data_q <= slot_data_d;
      ld_sel_q <= ld_sel_d;
      q_q <= q_d;
      oe_q <= oe_d;
      ret_a_q <= ret_a_d;
      ret_b_q <= ret_b_d;
    end
  end

  assign link.rdata = q_q;
  assign link.rdata_oe = oe_q;
  assign link.return_strobe_a = ret_a_q;
  assign link.return_strobe_b = ret_b_q;
  assign drive_code_out = zq_code_q;
  assign cal_pulse_out = cal_q;
  assign pll_locked_out = locked_q;
  assign single_clock_out = single_q;
endmodule

// >>> design/dsbsp_pkg.sv
// Shared constants and types for the burst SRAM port link and both of its ends.
// Assumes one 25 MHz system clock shared by the memory end and the controller end.
package dsbsp_pkg;

  localparam int WORD_W = 18;
  localparam int ADDR_W = 22;
  localparam int MEM_DEPTH = 2 ** ADDR_W;
  localparam int LANE0_LSB = 0;
  localparam int LANE0_MSB = 8;
  localparam int LANE1_LSB = 9;
  localparam int LANE1_MSB = 17;
  localparam int ZQ_CODE_W = 6;
  localparam logic [ZQ_CODE_W-1:0] ZQ_CODE_RST = 6'h20;

  localparam int CLK_PERIOD_NS = 40;
  localparam int PLL_LOCK_NS = 20000;
  localparam int PLL_LOCK_CYC = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PLL_STOP_NS = 30;
  localparam int PLL_STOP_CYC = (PLL_STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOCK_MARGIN_CYC = 4;
  localparam int ZQ_PERIOD_CYC = 1024;

  // Launch edges counted after a read command up to its first word.
  localparam logic [2:0] RD_EDGE_DDR2 = 3'h3;
  localparam logic [2:0] RD_EDGE_LEGACY = 3'h2;
  localparam int CT_SLOTS = 4;

  typedef enum logic [1:0] {
    CT_LOCK = 2'b00,
    CT_RUN = 2'b01,
    CT_STOP = 2'b10
  } dsbsp_ct_state_e;

endpackage

// >>> design/dsbsp_link_if.sv
// Pin-level link between the memory controller end and the burst SRAM end.
// Assumes both ends sample every signal on the shared system clock.
interface dsbsp_link_if
  import dsbsp_pkg::*;
();
  logic in_strobe_a;
  logic in_strobe_b;
  logic out_phase_a;
  logic out_phase_b;
  logic cmd_valid_n;
  logic read_not_write;
  logic pll_off_n;
  logic [ADDR_W-1:0] addr;
  logic [WORD_W-1:0] wdata;
  logic lane0_write_mask_n;
  logic lane1_write_mask_n;
  logic [WORD_W-1:0] rdata;
  logic rdata_oe;
  logic return_strobe_a;
  logic return_strobe_b;

  modport dev (
    input in_strobe_a, in_strobe_b, out_phase_a, out_phase_b, cmd_valid_n, read_not_write,
    input pll_off_n, addr, wdata, lane0_write_mask_n, lane1_write_mask_n,
    output rdata, rdata_oe, return_strobe_a, return_strobe_b
  );

  modport ctrl (
    output in_strobe_a, in_strobe_b, out_phase_a, out_phase_b, cmd_valid_n, read_not_write,
    output pll_off_n, addr, wdata, lane0_write_mask_n, lane1_write_mask_n,
    input rdata, rdata_oe, return_strobe_a, return_strobe_b
  );
endinterface

// >>> design/dsbsp_lane_merge.sv
// Merges one half-word into a stored word under two active-low byte-lane masks.
// Assumes purely combinational use by the memory end.
module dsbsp_lane_merge
  import dsbsp_pkg::*;
(
  input wire logic [WORD_W-1:0] old_in,
  input wire logic [WORD_W-1:0] new_in,
  input wire logic [1:0] mask_n_in,
  output logic [WORD_W-1:0] merged_out
);
  always_comb begin
    merged_out = old_in;
    if (!mask_n_in[0]) begin
      merged_out[LANE0_MSB:LANE0_LSB] = new_in[LANE0_MSB:LANE0_LSB]; // [R13]
    end
    if (!mask_n_in[1]) begin
      merged_out[LANE1_MSB:LANE1_LSB] = new_in[LANE1_MSB:LANE1_LSB]; // [R13]
    end
  end
endmodule

// >>> design/dsbsp_ctrl.sv
// Controller end of the burst SRAM port: makes the strobes, issues commands, captures reads.
// Assumes the memory end shares clk_in; strobes run at half the system clock rate.
module dsbsp_ctrl
  import dsbsp_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  dsbsp_link_if.ctrl link,
  input wire logic pll_bypass_in,
  input wire logic single_clock_in,
  input wire logic pll_reset_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [ADDR_W-1:0] req_addr_in,
  input wire logic [WORD_W-1:0] req_wdata0_in,
  input wire logic [WORD_W-1:0] req_wdata1_in,
  input wire logic [1:0] req_mask0_n_in,
  input wire logic [1:0] req_mask1_n_in,
  output logic req_ready_out,
  output logic link_up_out,
  output logic rsp_valid_out,
  output logic rsp_word_out,
  output logic [WORD_W-1:0] rsp_data_out
);
  dsbsp_ct_state_e st_q, st_d;
  logic [9:0] tmr_q, tmr_d;
  logic a_q, a_d, b_q, b_d, cv_n_q, cv_n_d, rnw_q, rnw_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [WORD_W-1:0] d_q, d_d, wb_d0_q, wb_d0_d, wb_d1_q, wb_d1_d, wc_d_q, wc_d_d;
  logic [1:0] m_q, m_d, wb_m0_q, wb_m0_d, wb_m1_q, wb_m1_d, wc_m_q, wc_m_d;
  logic wb_v_q, wb_v_d, wc_v_q, wc_v_d, accept, erise;
  logic ea_q, eb_q;
  logic [CT_SLOTS-1:0] rs_v_q, rs_v_d;
  logic [2:0] rs_cnt_q [CT_SLOTS];
  logic [2:0] rs_cnt_d [CT_SLOTS];
  logic [1:0] rs_sel_q, rs_sel_d;
  logic rsp_v_q, rsp_v_d, rsp_w_q, rsp_w_d;
  logic [WORD_W-1:0] rsp_d_q, rsp_d_d;

  assign req_ready_out = (st_q == CT_RUN) && !a_q && !rs_v_q[rs_sel_q]; // [R21]
  assign accept = req_valid_in && req_ready_out;
  assign erise = (link.return_strobe_a & ~ea_q) | (link.return_strobe_b & ~eb_q);

  always_comb begin
    logic [2:0] first;
    logic [2:0] n;
    first = pll_bypass_in ? RD_EDGE_LEGACY : RD_EDGE_DDR2;
    n = 3'h0;
    st_d = st_q;
    tmr_d = 10'(tmr_q + 10'h001);
    a_d = ~a_q; // [R6]
    b_d = a_q;
    cv_n_d = 1'b1;
    rnw_d = rnw_q;
    addr_d = addr_q;
    d_d = d_q;
    m_d = m_q;
    wb_v_d = wb_v_q;
    wb_d0_d = wb_d0_q;
    wb_d1_d = wb_d1_q;
    wb_m0_d = wb_m0_q;
    wb_m1_d = wb_m1_q;
    wc_v_d = wc_v_q;
    wc_d_d = wc_d_q;
    wc_m_d = wc_m_q;
    unique case (st_q)
      CT_LOCK: begin
        if (pll_bypass_in || (tmr_q == 10'(PLL_LOCK_CYC + LOCK_MARGIN_CYC))) begin
          st_d = CT_RUN; // [R21]
        end
      end
      CT_RUN: begin
        if (pll_reset_in && !a_q && !wb_v_q && !wc_v_q && (rs_v_q == '0)) begin
          st_d = CT_STOP;
          tmr_d = 10'h000;
          a_d = 1'b0; // [R17]
          b_d = 1'b0;
        end
      end
      CT_STOP: begin
        a_d = 1'b0; // [R5] [R17]
        b_d = 1'b0;
        if (tmr_q == 10'(PLL_STOP_CYC)) begin
          st_d = CT_LOCK;
          tmr_d = 10'h000;
        end
      end
    endcase
    if (st_q != CT_STOP && !a_q) begin
      d_d = wb_d0_q; // [R8]
      m_d = wb_v_q ? wb_m0_q : 2'h3;
      wc_v_d = wb_v_q;
      wc_d_d = wb_d1_q;
      wc_m_d = wb_m1_q; // [R15]
      wb_v_d = 1'b0;
      if (accept) begin
        cv_n_d = 1'b0; // [R8] [R9]
        rnw_d = ~req_write_in;
        addr_d = req_addr_in;
        wb_v_d = req_write_in;
        wb_d0_d = req_wdata0_in;
        wb_d1_d = req_wdata1_in;
        wb_m0_d = req_mask0_n_in;
        wb_m1_d = req_mask1_n_in;
      end
    end else if (st_q != CT_STOP && a_q) begin
      d_d = wc_d_q; // [R8]
      m_d = wc_v_q ? wc_m_q : 2'h3;
      wc_v_d = 1'b0;
    end
    rs_v_d = rs_v_q;
    rs_cnt_d = rs_cnt_q;
    rs_sel_d = rs_sel_q;
    rsp_v_d = 1'b0;
    rsp_w_d = rsp_w_q;
    rsp_d_d = rsp_d_q;
    for (int i = 0; i < CT_SLOTS; i++) begin
      if (rs_v_q[i] && erise) begin
        n = 3'(rs_cnt_q[i] + 3'h1);
        rs_cnt_d[i] = n;
        // The echo of each launch edge arrives one edge later and counting starts one echo early, so capture runs two counts past launch.
        if (n == 3'(first + 3'h2)) begin
          rsp_v_d = 1'b1; // [R9]
          rsp_w_d = 1'b0;
          rsp_d_d = link.rdata;
        end else if (n == 3'(first + 3'h3)) begin
          rsp_v_d = 1'b1; // [R9]
          rsp_w_d = 1'b1;
          rsp_d_d = link.rdata;
          rs_v_d[i] = 1'b0;
        end
      end
    end
    if (accept && !req_write_in) begin
      rs_v_d[rs_sel_q] = 1'b1;
      rs_cnt_d[rs_sel_q] = 3'h0;
      rs_sel_d = 2'(rs_sel_q + 2'h1);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= CT_LOCK;
      tmr_q <= 10'h000;
      a_q <= 1'b0;
      b_q <= 1'b0;
      cv_n_q <= 1'b1;
      rnw_q <= 1'b0;
      addr_q <= '0;
      d_q <= '0;
      m_q <= 2'h3;
      wb_v_q <= 1'b0;
      wb_d0_q <= '0;
      wb_d1_q <= '0;
      wb_m0_q <= 2'h3;
      wb_m1_q <= 2'h3;
      wc_v_q <= 1'b0;
      wc_d_q <= '0;
      wc_m_q <= 2'h3;
      ea_q <= 1'b0;
      eb_q <= 1'b0;
      rs_v_q <= '0;
      rs_cnt_q <= '{default: 3'h0};
      rs_sel_q <= 2'h0;
      rsp_v_q <= 1'b0;
      rsp_w_q <= 1'b0;
      rsp_d_q <= '0;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      a_q <= a_d;
      b_q <= b_d;
      cv_n_q <= cv_n_d;
      rnw_q <= rnw_d;
      addr_q <= addr_d;
      d_q <= d_d;
      m_q <= m_d;
      wb_v_q <= wb_v_d;
      wb_d0_q <= wb_d0_d;
      wb_d1_q <= wb_d1_d;
      wb_m0_q <= wb_m0_d;
      wb_m1_q <= wb_m1_d;
      wc_v_q <= wc_v_d;
      wc_d_q <= wc_d_d;
      wc_m_q <= wc_m_d;
      ea_q <= link.return_strobe_a;
      eb_q <= link.return_strobe_b;
      rs_v_q <= rs_v_d;
      rs_cnt_q <= rs_cnt_d;
      rs_sel_q <= rs_sel_d;
      rsp_v_q <= rsp_v_d;
      rsp_w_q <= rsp_w_d;
      rsp_d_q <= rsp_d_d;
    end
  end

  // Output phases track the input strobes with zero skew; single clock mode and the CT_STOP state park them high.
  assign link.in_strobe_a = a_q;
  assign link.in_strobe_b = b_q;
  assign link.out_phase_a = single_clock_in | (st_q == CT_STOP) | a_q; // [R17] [R19]
  assign link.out_phase_b = single_clock_in | (st_q == CT_STOP) | b_q; // [R17] [R19]
  assign link.cmd_valid_n = cv_n_q;
  assign link.read_not_write = rnw_q;
  assign link.pll_off_n = ~pll_bypass_in; // [R7]
  assign link.addr = addr_q;
  assign link.wdata = d_q;
  assign link.lane0_write_mask_n = m_q[0];
  assign link.lane1_write_mask_n = m_q[1];
  assign link_up_out = (st_q == CT_RUN);
  assign rsp_valid_out = rsp_v_q;
  assign rsp_word_out = rsp_w_q;
  assign rsp_data_out = rsp_d_q;
endmodule

// >>> tb/dsbsp_link_monitor.sv
// Concurrent checks on the link between the controller end and the memory end.
// Assumes it sees the link signals directly, all sampled on clk_in.
module dsbsp_link_monitor
  import dsbsp_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic in_strobe_a,
  input wire logic in_strobe_b,
  input wire logic cmd_valid_n,
  input wire logic read_not_write,
  input wire logic pll_off_n,
  input wire logic [WORD_W-1:0] rdata,
  input wire logic rdata_oe,
  input wire logic return_strobe_a,
  input wire logic return_strobe_b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sa_q;
  logic [5:0] rd_q;
  logic rd_cmd;
  logic wr_cmd;
  assign rd_cmd = in_strobe_a & ~sa_q & ~cmd_valid_n & read_not_write;
  assign wr_cmd = in_strobe_a & ~sa_q & ~cmd_valid_n & ~read_not_write;
  // Read history lets a rising output enable be traced back to its command.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sa_q <= 1'h0;
      rd_q <= 6'h00;
    end else begin
      sa_q <= in_strobe_a;
      rd_q <= {rd_q[4:0], rd_cmd};
    end
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence s_rd_cmd;
    rd_cmd;
  endsequence
  sequence s_two_words;
    rdata_oe ##1 rdata_oe;
  endsequence
  a_read_pll_latency: assert property (s_rd_cmd ##0 pll_off_n |-> ##4 s_two_words)
    else $error("read words not on time with pll on");
  a_read_legacy_latency: assert property (s_rd_cmd ##0 !pll_off_n |-> ##3 s_two_words)
    else $error("read words not on time with pll off");
  a_oe_has_cause: assert property ($rose(rdata_oe) |-> (pll_off_n ? rd_q[3] : rd_q[2]))
    else $error("read data driven without a read");
  a_float_when_idle: assert property (rd_q[5] && rd_q[4:0] == 5'h00 && !rd_cmd |-> ##[0:2] !rdata_oe)
    else $error("read data not floated after last read");
  a_stop_holds_data: assert property (in_strobe_a == $past(in_strobe_a) && in_strobe_b == $past(in_strobe_b)
    |=> $stable(rdata))
    else $error("read data changed while strobes stopped");
  a_echo_tracks: assert property ($past(in_strobe_a) != $past(in_strobe_b)
    |-> {return_strobe_a, return_strobe_b} == $past({in_strobe_a, in_strobe_b}))
    else $error("echo clocks do not follow launch clocks");
  a_write_frame: assert property (wr_cmd |=> in_strobe_b && cmd_valid_n ##1 in_strobe_a && !in_strobe_b)
    else $error("write data phases out of order");
  a_cmd_on_strobe: assert property (!cmd_valid_n |-> in_strobe_a && !in_strobe_b)
    else $error("command outside strobe a high phase");
  a_mode_static: assert property ($stable(pll_off_n))
    else $error("pll mode changed while running");
endmodule

// >>> tb/testbench.sv
// Self-checking bench: the controller end and the memory end joined by the link.
// Assumes a 25 MHz clock; inputs change 1 ns after each rising edge.
module testbench
  import dsbsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic w; logic [ADDR_W-1:0] a; logic [WORD_W-1:0] d0; logic [WORD_W-1:0] d1;
    logic [1:0] m0; logic [1:0] m1;} dsbsp_op_s;
  dsbsp_op_s rows [10] = '{'{1'h1, 22'h10, 18'h3FFFF, 18'h0, 2'h0, 2'h0}, '{1'h0, 22'h10, 18'h0, 18'h0, 2'h3, 2'h3},
    '{1'h1, 22'h10, 18'h0, 18'h3FFFF, 2'h2, 2'h1}, '{1'h0, 22'h10, 18'h0, 18'h0, 2'h3, 2'h3},
    '{1'h1, 22'h10, 18'h12345, 18'h0ABCD, 2'h3, 2'h3}, '{1'h0, 22'h10, 18'h0, 18'h0, 2'h3, 2'h3},
    '{1'h1, 22'h3FFFFF, 18'h1, 18'h2, 2'h0, 2'h0}, '{1'h1, 22'h20, 18'h15555, 18'h2AAAA, 2'h0, 2'h0},
    '{1'h0, 22'h3FFFFF, 18'h0, 18'h0, 2'h3, 2'h3}, '{1'h0, 22'h20, 18'h0, 18'h0, 2'h3, 2'h3}};
  dsbsp_op_s cur = '{1'h0, 22'h0, 18'h0, 18'h0, 2'h3, 2'h3};
  logic clk_in, rst_n_in = 1'h0, bypass = 1'h0, single = 1'h0, pll_rst = 1'h0, req_valid = 1'h0;
  logic [ZQ_CODE_W-1:0] zq = 6'h15;
  logic [ZQ_CODE_W-1:0] drive_code;
  logic cal, locked, single_out, ready, link_up, rsp_valid, rsp_word;
  logic [WORD_W-1:0] rsp_data;
  logic [WORD_W-1:0] mem [logic [ADDR_W:0]];
  int n_fail = 0, checks = 0, cyc = 0;
  dsbsp_link_if dsbsp_link_if_i ();
  dsbsp_device dsbsp_device_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .link(dsbsp_link_if_i),
    .impedance_ref_pin_in(zq), .drive_code_out(drive_code), .cal_pulse_out(cal), .pll_locked_out(locked),
    .single_clock_out(single_out));
  dsbsp_ctrl dsbsp_ctrl_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .link(dsbsp_link_if_i), .pll_bypass_in(bypass),
    .single_clock_in(single), .pll_reset_in(pll_rst), .req_valid_in(req_valid), .req_write_in(cur.w),
    .req_addr_in(cur.a), .req_wdata0_in(cur.d0), .req_wdata1_in(cur.d1), .req_mask0_n_in(cur.m0),
    .req_mask1_n_in(cur.m1), .req_ready_out(ready), .link_up_out(link_up), .rsp_valid_out(rsp_valid),
    .rsp_word_out(rsp_word), .rsp_data_out(rsp_data));
  dsbsp_link_monitor dsbsp_link_monitor_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .in_strobe_a(dsbsp_link_if_i.in_strobe_a), .in_strobe_b(dsbsp_link_if_i.in_strobe_b),
    .cmd_valid_n(dsbsp_link_if_i.cmd_valid_n), .read_not_write(dsbsp_link_if_i.read_not_write),
    .pll_off_n(dsbsp_link_if_i.pll_off_n), .rdata(dsbsp_link_if_i.rdata), .rdata_oe(dsbsp_link_if_i.rdata_oe),
    .return_strobe_a(dsbsp_link_if_i.return_strobe_a), .return_strobe_b(dsbsp_link_if_i.return_strobe_b));
  initial begin
    clk_in = 1'h0;
    forever #20 clk_in = ~clk_in;
  end
  task automatic final_report;
    if (n_fail == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 8000) begin
      n_fail++;
      final_report();
    end
  end
  task automatic chk(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic step;
    @(posedge clk_in);
    #1;
  endtask
  // A lane whose mask is high keeps its old contents.
  function automatic void put(input logic [ADDR_W:0] k, input logic [WORD_W-1:0] d, input logic [1:0] m);
    logic [WORD_W-1:0] v;
    v = mem.exists(k) ? mem[k] : '0;
    if (!m[0]) v[LANE0_MSB:LANE0_LSB] = d[LANE0_MSB:LANE0_LSB];
    if (!m[1]) v[LANE1_MSB:LANE1_LSB] = d[LANE1_MSB:LANE1_LSB];
    mem[k] = v;
  endfunction
  task automatic issue(input dsbsp_op_s o);
    int n;
    n = 0;
    // Reads wait so that a posted write ahead of them has surely been taken.
    if (!o.w) repeat (6) step();
    cur = o;
    req_valid = 1'h1;
    while (ready !== 1'h1 && n < 40) begin
      step();
      n++;
    end
    step();
    req_valid = 1'h0;
    n = 0;
    if (o.w) begin
      put({o.a, 1'h0}, o.d0, o.m0);
      put({o.a, 1'h1}, o.d1, o.m1);
      // Lets an edge pass so a following request is not raised in the step that lowered this one.
      step();
    end else begin
      while (rsp_valid !== 1'h1 && n < 20) begin
        step();
        n++;
      end
      chk(n, bypass ? 18'h4 : 18'h5);
      chk(rsp_word, 1'h0);
      chk(rsp_data, mem[{o.a, 1'h0}]);
      step();
      chk({rsp_valid, rsp_word}, 2'h3);
      chk(rsp_data, mem[{o.a, 1'h1}]);
    end
  endtask
  task automatic start(input logic b, input logic s);
    int n;
    rst_n_in = 1'h0;
    bypass = b;
    single = s;
    repeat (10) step();
    chk({drive_code, dsbsp_link_if_i.rdata_oe, dsbsp_link_if_i.cmd_valid_n}, {6'h20, 2'h1});
    rst_n_in = 1'h1;
    n = 0;
    while (!b && locked !== 1'h1 && n < 700) begin
      step();
      n++;
    end
    if (!b) chk(n >= PLL_LOCK_CYC && n <= PLL_LOCK_CYC + 3, 1'h1);
    n = 0;
    while (link_up !== 1'h1 && n < 700) begin
      step();
      n++;
    end
    chk(single_out, s);
  endtask
  initial begin
    int n;
    start(1'h0, 1'h0);
    foreach (rows[i]) issue(rows[i]);
    n = 0;
    while (cal !== 1'h1 && n < 1100) begin
      step();
      n++;
    end
    n = 0;
    do begin
      step();
      n++;
    end while (cal !== 1'h1 && n < 1100);
    chk(n, 18'd1024);
    step();
    chk(drive_code, zq);
    pll_rst = 1'h1;
    n = 0;
    while (locked !== 1'h0 && n < 40) begin
      step();
      n++;
    end
    pll_rst = 1'h0;
    chk(locked, 1'h0);
    n = 0;
    while (link_up !== 1'h1 && n < 700) begin
      step();
      n++;
    end
    chk({locked, link_up}, 2'h3);
    issue(rows[9]);
    start(1'h1, 1'h1);
    foreach (rows[i]) issue(rows[i]);
    final_report();
  end
endmodule
